//--- src/omms_pkg.sv
// constants and carrier types of the optical module management block
// assumes a 100 MHz system clock and an 8-bit register port with 10-bit addresses
package omms_pkg;

  // ----------------------------------------------------------------
  // two-wire device addresses (7-bit form, r/w bit stripped)
  // ----------------------------------------------------------------
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam int MAP_BYTES = 256;
  localparam int NUM_MON = 5;

  // ----------------------------------------------------------------
  // layout of the two byte maps
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_WP_LIMIT = 8'h80;
  localparam logic [7:0] THR_BASE = 8'h00;
  localparam logic [7:0] THR_END = 8'h28;
  localparam logic [7:0] CALOFF_BASE = 8'h4c;
  localparam logic [7:0] LIVE_BASE = 8'h60;
  localparam logic [7:0] LIVE_END = 8'h78;
  localparam logic [7:0] STAT_BYTE = 8'h6e;
  localparam logic [7:0] ALARM_HI_BYTE = 8'h70;
  localparam logic [7:0] ALARM_LO_BYTE = 8'h71;
  localparam logic [7:0] WARN_HI_BYTE = 8'h74;
  localparam logic [7:0] WARN_LO_BYTE = 8'h75;
  localparam int SB_TXDIS = 7;
  localparam int SB_FAULT = 2;
  localparam int SB_LOS = 1;
  localparam int SB_CALEXT = 0;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam logic [9:0] REG_CTRL = 10'h100;
  localparam logic [9:0] REG_STATUS = 10'h101;
  localparam logic [9:0] REG_CLEAR = 10'h102;
  localparam logic [9:0] REG_ENABLE = 10'h103;
  localparam int CTRL_CAL_EXT = 0;
  localparam int CTRL_ID_WP = 1;
  localparam logic CAL_EXT_RESET = 1'b0;
  localparam logic ID_WP_RESET = 1'b1;
  localparam int NUM_EV = 5;
  localparam int EV_ALARM = 0;
  localparam int EV_WARN = 1;
  localparam int EV_LOS = 2;
  localparam int EV_FAULT = 3;
  localparam int EV_WRITE = 4;

  // ----------------------------------------------------------------
  // timing and synchroniser lanes
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_OFF_TIME_US = 10;
  localparam int TX_OFF_CYCLES = TX_OFF_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int SYNC_BITS = 5;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_TXDIS = 2;
  localparam int SY_LOS = 3;
  localparam int SY_FAULT = 4;

  typedef struct packed {
    logic [15:0] vcc;
    logic [15:0] rxpow;
    logic [15:0] txpow;
    logic [15:0] bias;
    logic [15:0] temp;
  } omms_mon_s;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } omms_bus_s;

endpackage

//--- src/omms_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
// assumes every bit is an independent level; no bus coherence is given
`timescale 1ns/1ps
module omms_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '1
) (
  input wire logic clk_sys,           // system clock
  input wire logic reset_n,           // async reset, active low
  input wire logic [WIDTH-1:0] d,     // asynchronous levels
  output logic [WIDTH-1:0] q          // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } omms_sync_s;

  omms_sync_s st;
  omms_sync_s next_st;

  // first stage feeds only the second stage
  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= {RST, RST};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule

//--- src/omms_mgmt.sv
// management slave of a pluggable optical module: two-wire maps, monitors, status pins
// assumes scl/sda and the module pins are asynchronous, mon comes from on-chip converters
//
// What this block does
// - A 256-byte identification map is readable over the two-wire bus at address 1010000x.
// - Diagnostic accesses are answered at address 1010001x without touching the identification map.
// - Serial data is captured on the rising clock edge and written only where not write-protected.
// - Read data on the serial data line changes only on the falling clock edge.
// - The data line is two-way and the module detects start and stop conditions made by the host.
// - Maps are 8-bit words reached by a given address or by an address that advances per byte.
// - Temperature, bias, transmit power, receive power and supply voltage are readable live.
// - Alarm and warning flags are set whenever a monitored value leaves its set range.
// - By default the reported values are calibrated inside the module.
// - The loss-of-signal output is 0 during normal reception and 1 when no signal is seen.
// - The optical output is shut off within 10 us of the transmit disable input going high.
// - The transmit fault output is high on a laser fault and low otherwise.
// - Transmit disable high or open disables the transmitter and low enables it.
// - The presence pin is held low so the host sees a module inserted.
`timescale 1ns/1ps
module omms_mgmt (
  input wire logic clk_sys,                // 100 MHz system clock
  input wire logic reset_n,                // async reset, active low
  input wire logic scl_in,                 // two-wire clock from host
  input wire logic sda_in,                 // two-wire data, line level
  output logic sda_out,                    // data drive value, always low
  output logic sda_oe,                     // high while pulling data low
  input wire logic tx_disable,             // transmit disable pin level
  input wire logic rx_no_signal,           // receive detector: no light
  input wire logic laser_fault,            // laser driver fault level
  input wire omms_pkg::omms_mon_s mon,     // raw monitor samples
  output logic tx_laser_en,                // laser output enable
  output logic tx_fault,                   // fault pin, high on fault
  output logic rx_signal_lost,             // loss-of-signal pin
  output logic mod_present_n,              // presence pin, low = present
  input wire omms_pkg::omms_bus_s bus,     // register port request
  output logic [7:0] rdata,                // read data, cycle after rd
  output logic irq                         // level interrupt
);
  import omms_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_DEV, S_DEV_ACK, S_WORD, S_WORD_ACK, S_WDATA, S_WDATA_ACK, S_RDATA
  } omms_fsm_e;

  typedef struct packed {
    omms_fsm_e fsm;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic [7:0] txb;
    logic sel;
    logic rw;
    logic nack;
    logic oe;
    logic scl_p;
    logic sda_p;
    logic [NUM_MON-1:0][15:0] live;
    logic [NUM_MON-1:0] ahi;
    logic [NUM_MON-1:0] alo;
    logic [NUM_MON-1:0] whi;
    logic [NUM_MON-1:0] wlo;
    logic cal_ext;
    logic id_wp;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] enable;
    logic [7:0] rdata;
    logic irq;
    logic laser_en;
    logic fault;
    logic rx_lost;
  } omms_regs_s;

  omms_regs_s st;
  omms_regs_s next_st;
  logic [7:0] id_mem [MAP_BYTES];
  logic [7:0] diag_mem [MAP_BYTES];
  logic [SYNC_BITS-1:0] sy;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic i2c_we, prot;
  logic [7:0] host_byte;
  logic [NUM_EV-1:0] ev, clr;
  logic [NUM_MON-1:0][15:0] raw, next_live, cal_off;
  logic [NUM_MON-1:0] ahi_w, alo_w, whi_w, wlo_w;

  // ----------------------------------------------------------------
  // pin synchronisers and line edges
  // ----------------------------------------------------------------
  // fault lane resets low: an idle-high reset would fake a fault event and a fault pulse after every reset
  omms_sync #(.WIDTH(SYNC_BITS), .RST(5'h0f)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .d({laser_fault, rx_no_signal, tx_disable, sda_in, scl_in}),
    .q(sy)
  );

  // the bus clock is only sampled here, never driven
  assign scl_s = sy[SY_SCL];
  assign sda_s = sy[SY_SDA];
  assign scl_rise = scl_s & ~st.scl_p;
  assign scl_fall = ~scl_s & st.scl_p;
  // data moving while clock is high marks start and stop
  assign start_det = scl_s & st.scl_p & st.sda_p & ~sda_s;
  assign stop_det = scl_s & st.scl_p & ~st.sda_p & sda_s;

  // ----------------------------------------------------------------
  // monitor channels: calibration and range checks
  // ----------------------------------------------------------------
  assign raw = mon;
  for (genvar i = 0; i < NUM_MON; i++) begin : g_mon
    localparam int C = int'(CALOFF_BASE) + 2 * i;
    localparam int T = int'(THR_BASE) + 8 * i;
    assign cal_off[i] = {diag_mem[C], diag_mem[C + 1]};
    // offsets stay in the map so an external mode host can apply them itself
    assign next_live[i] = st.cal_ext ? raw[i] : 16'(raw[i] + cal_off[i]);
    // unsigned compare; signed temperature needs biased thresholds
    assign ahi_w[i] = st.live[i] > {diag_mem[T], diag_mem[T + 1]};
    assign alo_w[i] = st.live[i] < {diag_mem[T + 2], diag_mem[T + 3]};
    assign whi_w[i] = st.live[i] > {diag_mem[T + 4], diag_mem[T + 5]};
    assign wlo_w[i] = st.live[i] < {diag_mem[T + 6], diag_mem[T + 7]};
  end

  // ----------------------------------------------------------------
  // byte seen by the host at the current pointer
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] off;
    off = st.ptr - LIVE_BASE;
    if (!st.sel) begin
      host_byte = id_mem[st.ptr];
    end else if (st.ptr >= LIVE_BASE && st.ptr < LIVE_BASE + 8'h0a) begin
      host_byte = off[0] ? st.live[off[3:1]][7:0] : st.live[off[3:1]][15:8];
    end else if (st.ptr == STAT_BYTE) begin
      host_byte = 8'h00;
      host_byte[SB_TXDIS] = ~st.laser_en;
      host_byte[SB_FAULT] = st.fault;
      host_byte[SB_LOS] = st.rx_lost;
      host_byte[SB_CALEXT] = st.cal_ext;
    end else if (st.ptr == ALARM_HI_BYTE) begin
      host_byte = {3'h0, st.ahi};
    end else if (st.ptr == ALARM_LO_BYTE) begin
      host_byte = {3'h0, st.alo};
    end else if (st.ptr == WARN_HI_BYTE) begin
      host_byte = {3'h0, st.whi};
    end else if (st.ptr == WARN_LO_BYTE) begin
      host_byte = {3'h0, st.wlo};
    end else begin
      host_byte = diag_mem[st.ptr];
    end
  end

  // live area of the diagnostic map, and the lower id half while id_wp is set, are read-only
  assign prot = st.sel ? (st.ptr >= LIVE_BASE && st.ptr < LIVE_END)
                       : (st.id_wp && st.ptr < ID_WP_LIMIT);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    i2c_we = 1'b0;
    ev = '0;
    clr = '0;
    next_st.scl_p = scl_s;
    next_st.sda_p = sda_s;
    // serial protocol; start and stop override any bit in flight
    if (start_det) begin
      next_st.fsm = S_DEV;
      next_st.cnt = 4'h0;
      next_st.oe = 1'b0;
    end else if (stop_det) begin
      next_st.fsm = S_IDLE;
      next_st.oe = 1'b0;
    end else if (scl_rise) begin
      case (st.fsm)
        S_DEV, S_WORD, S_WDATA: begin
          next_st.sh = {st.sh[6:0], sda_s};
          next_st.cnt = st.cnt + 4'h1;
        end
        S_RDATA: begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt == 4'h8) begin
            next_st.nack = sda_s;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st.fsm)
        S_DEV: begin
          if (st.cnt == 4'h8) begin
            if (st.sh[7:1] == ID_DEV_ADDR || st.sh[7:1] == DIAG_DEV_ADDR) begin
              next_st.sel = (st.sh[7:1] == DIAG_DEV_ADDR);
              next_st.rw = st.sh[0];
              next_st.oe = 1'b1;
              next_st.fsm = S_DEV_ACK;
            end else begin
              next_st.fsm = S_IDLE;
            end
          end
        end
        S_DEV_ACK: begin
          next_st.cnt = 4'h0;
          if (st.rw) begin
            next_st.txb = host_byte;
            next_st.oe = ~host_byte[7];
            next_st.ptr = st.ptr + 8'h01;
            next_st.fsm = S_RDATA;
          end else begin
            next_st.oe = 1'b0;
            next_st.fsm = S_WORD;
          end
        end
        S_WORD: begin
          if (st.cnt == 4'h8) begin
            next_st.ptr = st.sh;
            next_st.oe = 1'b1;
            next_st.fsm = S_WORD_ACK;
          end
        end
        S_WORD_ACK, S_WDATA_ACK: begin
          next_st.oe = 1'b0;
          next_st.cnt = 4'h0;
          next_st.fsm = S_WDATA;
        end
        S_WDATA: begin
          if (st.cnt == 4'h8) begin
            // protected bytes are still acknowledged, just not stored
            i2c_we = ~prot;
            ev[EV_WRITE] = ~prot;
            next_st.ptr = st.ptr + 8'h01;
            next_st.oe = 1'b1;
            next_st.fsm = S_WDATA_ACK;
          end
        end
        S_RDATA: begin
          if (st.cnt == 4'h8) begin
            next_st.oe = 1'b0;
          end else if (st.cnt == 4'h9) begin
            if (st.nack) begin
              next_st.fsm = S_IDLE;
            end else begin
              next_st.txb = host_byte;
              next_st.oe = ~host_byte[7];
              next_st.ptr = st.ptr + 8'h01;
              next_st.cnt = 4'h0;
            end
          end else begin
            next_st.txb = {st.txb[6:0], 1'b0};
            next_st.oe = ~st.txb[6];
          end
        end
        default: begin
        end
      endcase
    end
    // monitors and pins
    next_st.live = next_live;
    next_st.ahi = ahi_w;
    next_st.alo = alo_w;
    next_st.whi = whi_w;
    next_st.wlo = wlo_w;
    next_st.laser_en = ~sy[SY_TXDIS];
    next_st.fault = sy[SY_FAULT];
    next_st.rx_lost = sy[SY_LOS];
    ev[EV_ALARM] = |{ahi_w, alo_w} & ~|{st.ahi, st.alo};
    ev[EV_WARN] = |{whi_w, wlo_w} & ~|{st.whi, st.wlo};
    ev[EV_LOS] = sy[SY_LOS] & ~st.rx_lost;
    ev[EV_FAULT] = sy[SY_FAULT] & ~st.fault;
    // register port
    next_st.rdata = 8'h00;
    if (bus.wr) begin
      if (bus.addr == REG_CTRL) begin
        next_st.cal_ext = bus.wdata[CTRL_CAL_EXT];
        next_st.id_wp = bus.wdata[CTRL_ID_WP];
      end else if (bus.addr == REG_ENABLE) begin
        next_st.enable = bus.wdata[NUM_EV-1:0];
      end else if (bus.addr == REG_CLEAR) begin
        clr = bus.wdata[NUM_EV-1:0];
      end
    end else if (bus.rd) begin
      if (bus.addr[9:8] == 2'h0) begin
        next_st.rdata = id_mem[bus.addr[7:0]];
      end else if (bus.addr == REG_CTRL) begin
        next_st.rdata = {6'h00, st.id_wp, st.cal_ext};
      end else if (bus.addr == REG_STATUS) begin
        next_st.rdata = {3'h0, st.status};
      end else if (bus.addr == REG_ENABLE) begin
        next_st.rdata = {3'h0, st.enable};
      end
    end
    // a new event beats a clear in the same cycle
    next_st.status = (st.status & ~clr) | ev;
    next_st.irq = |(next_st.status & next_st.enable);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.fsm <= S_IDLE;
      st.scl_p <= 1'b1;
      st.sda_p <= 1'b1;
      st.cal_ext <= CAL_EXT_RESET;
      st.id_wp <= ID_WP_RESET;
      st.rx_lost <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // byte maps; hi thresholds reset to all ones so nothing alarms
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int a = 0; a < MAP_BYTES; a++) begin
        id_mem[a] <= 8'h00;
        diag_mem[a] <= (a < int'(THR_END) && a[1] == 1'b0) ? 8'hff : 8'h00;
      end
    end else begin
      if (i2c_we && st.sel) begin
        diag_mem[st.ptr] <= st.sh;
      end
      if (i2c_we && !st.sel) begin
        id_mem[st.ptr] <= st.sh;
      end else if (bus.wr && bus.addr[9:8] == 2'h0) begin
        id_mem[bus.addr[7:0]] <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = st.oe;
  assign tx_laser_en = st.laser_en;
  assign tx_fault = st.fault;
  assign rx_signal_lost = st.rx_lost;
  assign mod_present_n = 1'b0;
  assign rdata = st.rdata;
  assign irq = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int OFF_BOUND = (TX_OFF_CYCLES < 3) ? TX_OFF_CYCLES : 3;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_id_ack;
    (st.fsm == S_DEV && scl_fall && st.cnt == 4'h8 && st.sh[7:1] == ID_DEV_ADDR) |=> st.oe && !st.sel;
  endproperty
  a_id_ack: assert property (p_id_ack) else $error("id address not acknowledged");
  property p_diag_ack;
    (st.fsm == S_DEV && scl_fall && st.cnt == 4'h8 && st.sh[7:1] == DIAG_DEV_ADDR) |=> st.oe && st.sel;
  endproperty
  a_diag_ack: assert property (p_diag_ack) else $error("diag address not acknowledged");
  property p_capture;
    (st.sh != $past(st.sh)) |-> $past(scl_rise);
  endproperty
  a_capture: assert property (p_capture) else $error("data shifted off a rising edge");
  property p_oe_edge;
    (st.oe != $past(st.oe)) |-> $past(scl_fall || start_det || stop_det);
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data drive moved off a falling edge");
  property p_start;
    start_det |=> st.fsm == S_DEV && st.cnt == 4'h0 && !st.oe;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_autoinc;
    (st.fsm == S_WDATA && scl_fall && st.cnt == 4'h8) |=> st.ptr == $past(st.ptr) + 8'h01;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("pointer did not advance");
  property p_alarm;
    (|{ahi_w, alo_w}) |=> (|{st.ahi, st.alo});
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag missed");
  property p_cal;
    !$past(st.cal_ext) |-> st.live[0] == 16'($past(raw[0]) + $past(cal_off[0]));
  endproperty
  a_cal: assert property (p_cal) else $error("internal calibration wrong");
  property p_los;
    rx_no_signal [*4] |-> rx_signal_lost;
  endproperty
  a_los: assert property (p_los) else $error("loss of signal not shown");
  property p_txoff;
    $rose(tx_disable) |-> ##[1:OFF_BOUND] !tx_laser_en;
  endproperty
  a_txoff: assert property (p_txoff) else $error("laser not shut off in time");
  property p_fault;
    laser_fault [*4] |-> tx_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not shown");
  property p_foreign;
    (st.fsm == S_DEV && scl_fall && st.cnt == 4'h8 && st.sh[7:1] != ID_DEV_ADDR
      && st.sh[7:1] != DIAG_DEV_ADDR) |=> !st.oe && st.fsm == S_IDLE;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");

endmodule

//--- testbench/omms_host.sv
// host-side two-wire master model for the management block
// assumes dev_oe comes from the block and the data line has a pull-up
`timescale 1ns/1ps
module omms_host (
  input wire logic clk_sys, // system clock
  input wire logic dev_oe,  // block pulls data low
  output logic scl,         // serial clock, host made
  output wire logic sda     // resolved data line
);
  logic host_oe;
  // released line floats to the pull-up level
  assign sda = ~(host_oe | dev_oe);
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    host_oe <= 1'b0;
    wt(8);
    scl <= 1'b1;
    wt(8);
    host_oe <= 1'b1;
    wt(8);
    scl <= 1'b0;
    wt(8);
  endtask
  task automatic stop();
    host_oe <= 1'b1;
    wt(8);
    scl <= 1'b1;
    wt(8);
    host_oe <= 1'b0;
    wt(8);
  endtask
  // one 160 ns bit; data moves only while clock low
  task automatic bit_x(input logic b, output logic r);
    host_oe <= ~b;
    wt(4);
    scl <= 1'b1;
    wt(8);
    r = sda;
    scl <= 1'b0;
    wt(4);
  endtask
  // msb first, ninth bit is the acknowledge slot
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(last, a);
    ack = ~a;
  endtask
endmodule

//--- testbench/tb_optical_module_mgmt_serial.sv
// self-checking bench for the optical module management block
// assumes omms_host plays the two-wire master; pins and register port driven here
`timescale 1ns/1ps
module tb_optical_module_mgmt_serial;
  import omms_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic tx_disable = 1'b1;
  logic rx_no_signal = 1'b1;
  logic laser_fault = 1'b0;
  omms_mon_s mon = '0;
  omms_bus_s bus = '0;
  logic scl, sda, sda_out, sda_oe, tx_laser_en, tx_fault, rx_signal_lost, mod_present_n, irq;
  logic [7:0] rdata;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk_sys = ~clk_sys;
  omms_mgmt dut (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .tx_disable(tx_disable), .rx_no_signal(rx_no_signal), .laser_fault(laser_fault),
    .mon(mon), .tx_laser_en(tx_laser_en), .tx_fault(tx_fault), .rx_signal_lost(rx_signal_lost),
    .mod_present_n(mod_present_n), .bus(bus), .rdata(rdata), .irq(irq));
  omms_host h (.clk_sys(clk_sys), .dev_oe(sda_oe), .scl(scl), .sda(sda));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [9:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 q = rdata;
  endtask
  task automatic lwr(input logic [7:0] dev, input logic [7:0] w, input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic a0, a1;
    h.start();
    h.byte_x(dev, 1'b1, q, a0);
    h.byte_x(w, 1'b1, q, a1);
    h.byte_x(d, 1'b1, q, ack);
    h.stop();
    ack = ack & a0 & a1;
  endtask
  // two-byte sequential read after a pointer set, master nacks the last
  task automatic lrd(input logic [7:0] dev, input logic [7:0] w, output logic [15:0] v);
    logic [7:0] q;
    logic a;
    h.start();
    h.byte_x(dev, 1'b1, q, a);
    h.byte_x(w, 1'b1, q, a);
    h.start();
    h.byte_x(dev | 8'h01, 1'b1, q, a);
    h.byte_x(8'hff, 1'b0, v[15:8], a);
    h.byte_x(8'hff, 1'b1, v[7:0], a);
    h.stop();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_pins();
    logic [7:0] q;
    reg_rd(REG_STATUS, q);
    check(q, 8'h00);
    check(mod_present_n, 1'b0);
    check(sda_out, 1'b0);
    check(tx_laser_en, 1'b0);
    @(posedge clk_sys);
    tx_disable <= 1'b0;
    laser_fault <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check({tx_laser_en, tx_fault}, 2'b11);
    @(posedge clk_sys);
    tx_disable <= 1'b1;
    laser_fault <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check({tx_laser_en, tx_fault}, 2'b00);
  endtask
  task automatic t_irq();
    logic [7:0] q;
    reg_wr(REG_ENABLE, 8'h04);
    rx_no_signal <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check({rx_signal_lost, irq}, 2'b00);
    @(posedge clk_sys);
    rx_no_signal <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 check({rx_signal_lost, irq}, 2'b11);
    reg_rd(REG_STATUS, q);
    check(q & 8'h04, 8'h04);
    reg_wr(REG_CLEAR, 8'h04);
    repeat (2) @(posedge clk_sys);
    #1 check(irq, 1'b0);
    reg_rd(10'h200, q);
    check(q, 8'h00);
  endtask
  // temp alarm-high threshold dropped below the live value
  task automatic t_diag();
    logic a;
    logic [15:0] v;
    @(posedge clk_sys);
    mon <= '{vcc: 16'h0, rxpow: 16'h0, txpow: 16'h0, bias: 16'h0, temp: 16'h1234};
    lwr(8'ha2, 8'h00, 8'h01, a);
    check(a, 1'b1);
    lrd(8'ha2, 8'h60, v);
    check(v, 16'h1234);
    lrd(8'ha2, 8'h00, v);
    check(v, 16'h01ff);
    lrd(8'ha2, ALARM_HI_BYTE, v);
    check(v[15:8], 8'h01);
  endtask
  task automatic t_idmap();
    logic a;
    logic [7:0] q;
    logic [15:0] v;
    lwr(8'ha0, 8'h10, 8'h5a, a);
    reg_rd(10'h010, q);
    check({a, q}, 9'h100);
    lwr(8'ha0, 8'h90, 8'h5a, a);
    lrd(8'ha0, 8'h90, v);
    check(v[15:8], 8'h5a);
    reg_rd(10'h000, q);
    check(q, 8'h00);
    lwr(8'ha4, 8'h00, 8'h00, a);
    check(a, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_pins();
    t_irq();
    t_diag();
    t_idmap();
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
endmodule
